// ===== rtl/lcc_pkg.sv
// Purpose: shared constants and types of the light conversion controller
// Assumes: 200 MHz mclk, two 16-bit integrating converters outside
// Notes:   integration times are kept in microseconds, cycles derived
package lcc_pkg;

	localparam int CLK_MHZ   = 200;
	localparam int RES_W     = 16;
	localparam int PERSIST_W = 4;

	// serial bus rates of the two variants
	localparam int SMB_KHZ      = 100;
	localparam int I2C_KHZ      = 400;
	localparam int SMB_HALF_CYC = (CLK_MHZ * 1000) / (2 * SMB_KHZ);
	localparam int I2C_HALF_CYC = (CLK_MHZ * 1000) / (2 * I2C_KHZ);

	// nominal integration times
	localparam int INTEG_US_S   = 13700;
	localparam int INTEG_US_M   = 101000;
	localparam int INTEG_US_L   = 402000;
	localparam int INTEG_CYC_S  = INTEG_US_S * CLK_MHZ;
	localparam int INTEG_CYC_M  = INTEG_US_M * CLK_MHZ;
	localparam int INTEG_CYC_L  = INTEG_US_L * CLK_MHZ;

	// integration time select codes
	localparam logic [1:0] INTEG_SEL_S = 2'h0;
	localparam logic [1:0] INTEG_SEL_M = 2'h1;
	localparam logic [1:0] INTEG_SEL_L = 2'h2;

	// reset values
	localparam logic [6:0]  ADDR_RST = 7'h00;
	localparam logic [RES_W-1:0] RES_RST = 16'h0000;
	localparam logic [31:0] CNT_RST  = 32'h0000_0000;
	localparam logic [PERSIST_W-1:0] PCNT_RST = 4'h0;

	typedef struct packed {
		logic                 power_on;
		logic                 high_gain;
		logic [1:0]           integ;
		logic [PERSIST_W-1:0] persist;
		logic                 int_en;
	} lcc_cfg_t;

	typedef struct packed {
		logic [RES_W-1:0] upper;
		logic [RES_W-1:0] lower;
	} lcc_thr_t;

	typedef struct packed {
		logic [RES_W-1:0] ch0;
		logic [RES_W-1:0] ch1;
	} lcc_pair_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_INTEG = 2'b01,
		ST_XFER  = 2'b10
	} lcc_state_t;

endpackage : lcc_pkg

// ===== rtl/lcc_ctrl.sv
// Purpose: conversion sequencing, result buffering, threshold interrupt
// Assumes: host register decode lives elsewhere and drives plain ports
// Notes:   adc_res is sampled on the last integration cycle
//
// Contract
// R1: both channels integrate over the same window
// R2: finished results go to channel 0/1 registers
// R3: data registers never change during a host read
// R4: next integration starts automatically after transfer
// R5: each result is 16-bit unsigned
// R6: flag values above upper or below lower
// R7: interrupt only after programmed persistence
// R8: level variant holds interrupt until host clear
// R9: bus-alert variant also releases on alert response
// R10: interrupt pin is open drain, low when asserted
// R11: two-wire bus, 100 kHz or 400 kHz
// R12: three-level strap chooses slave address
// R13: host sets gain and integration time
// R14: host can select power-down mode
// R15: power-down halts conversion, port stays alive
module lcc_ctrl #(
	parameter bit        SMBUS_VARIANT = 1'b0,
	parameter int        INTEG_CYC_S   = lcc_pkg::INTEG_CYC_S,
	parameter int        INTEG_CYC_M   = lcc_pkg::INTEG_CYC_M,
	parameter int        INTEG_CYC_L   = lcc_pkg::INTEG_CYC_L,
	// slave addresses per strap level, values arbitrary
	parameter logic [6:0] ADDR_GND     = 7'h20,
	parameter logic [6:0] ADDR_FLOAT   = 7'h21,
	parameter logic [6:0] ADDR_VDD     = 7'h22
) (
	// clock and reset
	input  wire logic               mclk,
	input  wire logic               rstn,
	// host configuration
	input  wire lcc_pkg::lcc_cfg_t  cfg,
	input  wire lcc_pkg::lcc_thr_t  thr,
	input  wire logic               host_rd_busy,
	input  wire logic               int_clear,
	input  wire logic               alert_resp,
	// converter side
	input  wire lcc_pkg::lcc_pair_t adc_res,
	output      logic               integ_run,
	output      logic               adc_gain,
	// results
	output      lcc_pkg::lcc_pair_t data,
	output      logic               data_new,
	// pins
	input  wire logic               scl_pin,
	input  wire logic               strap_hi_pin,
	input  wire logic               strap_lo_pin,
	output      logic               int_o,
	output      logic               int_oe,
	// status
	output      logic [6:0]         slave_addr,
	output      logic               bus_fast_seen
);
	import lcc_pkg::*;

	// each window needs one open cycle before its capture cycle
	if (INTEG_CYC_S < 2 || INTEG_CYC_M < 2 ||
			INTEG_CYC_L < 2) begin : g_bad_integ
		$error("integration counts must be at least 2");
	end

	localparam int HALF_CYC = SMBUS_VARIANT ? SMB_HALF_CYC : I2C_HALF_CYC;
	// edges until both strap synchroniser stages hold the pin value
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	function automatic logic [31:0] integ_limit(input logic [1:0] sel);
		unique case (sel)
			INTEG_SEL_S: integ_limit = 32'(INTEG_CYC_S - 1);
			INTEG_SEL_M: integ_limit = 32'(INTEG_CYC_M - 1);
			default:     integ_limit = 32'(INTEG_CYC_L - 1);
		endcase
	endfunction : integ_limit

	lcc_state_t state;
	logic [31:0] cnt;
	lcc_pair_t   shadow;
	logic        shadow_full;
	logic        conv_end;
	logic        outside;
	logic [PERSIST_W-1:0] pcnt;
	logic [PERSIST_W-1:0] next_pcnt;
	logic        fire;
	logic        clear_any;
	logic [1:0]  scl_s, hi_s, lo_s;
	logic        strap_done;
	logic [1:0]  strap_age;
	logic [31:0] high_cnt;

	// conversion sequencer
	// >= so a shorter time picked mid-window ends it instead of wrapping
	assign conv_end = cfg.power_on && (state == ST_INTEG) &&
		(cnt >= integ_limit(cfg.integ));

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
			cnt   <= CNT_RST;
		end else if (!cfg.power_on) begin // R14 R15
			state <= ST_IDLE;
			cnt   <= CNT_RST;
		end else begin
			unique case (state)
				ST_IDLE: state <= ST_INTEG;
				ST_INTEG: begin
					cnt <= cnt + 32'h0000_0001;
					if (conv_end) begin // R13
						state <= ST_XFER;
						cnt   <= CNT_RST;
					end
				end
				ST_XFER: state <= ST_INTEG; // R4
				default: state <= ST_IDLE;
			endcase
		end
	end

	// one window drives both converters together
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			integ_run <= 1'b0;
		else
			integ_run <= cfg.power_on && (state == ST_INTEG) && !conv_end; // R1
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			adc_gain <= 1'b0;
		else
			adc_gain <= cfg.high_gain; // R13
	end

	// shadow stage lets a read finish before the visible copy moves
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			shadow      <= '0;
			shadow_full <= 1'b0;
		end else if (conv_end) begin
			shadow.ch0  <= adc_res.ch0; // R2 R5
			shadow.ch1  <= adc_res.ch1; // R2 R5
			shadow_full <= 1'b1;
		end else if (shadow_full && !host_rd_busy) begin
			shadow_full <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			data     <= '0;
			data_new <= 1'b0;
		end else begin
			data_new <= 1'b0;
			if (shadow_full && !host_rd_busy) begin // R3
				data     <= shadow;
				data_new <= 1'b1;
			end
		end
	end

	// threshold check on broadband channel, persistence counted in conversions
	assign outside = (adc_res.ch0 > thr.upper) || (adc_res.ch0 < thr.lower); // R6
	assign next_pcnt = (pcnt == {PERSIST_W{1'b1}}) ? pcnt : pcnt + 4'h1;
	assign fire = conv_end && outside &&
		(next_pcnt >= ((cfg.persist == PCNT_RST) ? 4'h1 : cfg.persist)); // R7

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			pcnt <= PCNT_RST;
		else if (!cfg.power_on)
			pcnt <= PCNT_RST; // R15
		else if (conv_end)
			pcnt <= outside ? next_pcnt : PCNT_RST; // R7
	end

	// a new event beats a clear in the same cycle
	assign clear_any = int_clear || (SMBUS_VARIANT && alert_resp); // R8 R9

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			int_oe <= 1'b0;
		else if (fire && cfg.int_en)
			int_oe <= 1'b1; // R6 R8
		else if (clear_any)
			int_oe <= 1'b0; // R9
	end

	// pin is only ever pulled low, never driven high
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			int_o <= 1'b0;
		else
			int_o <= 1'b0; // R10
	end

	// pin synchronisers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			scl_s <= 2'h3;
			hi_s  <= 2'h0;
			lo_s  <= 2'h0;
		end else begin
			scl_s <= {scl_s[0], scl_pin};
			hi_s  <= {hi_s[0], strap_hi_pin};
			lo_s  <= {lo_s[0], strap_lo_pin};
		end
	end

	// strap is caught once after reset; later pin changes are ignored
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			slave_addr <= ADDR_RST;
			strap_done <= 1'b0;
			strap_age  <= 2'h0;
		end else if (!strap_done) begin
			if (strap_age != STRAP_SETTLE) begin
				strap_age <= strap_age + 2'h1;
			end else begin
				strap_done <= 1'b1;
				if (hi_s[1])
					slave_addr <= ADDR_VDD; // R12
				else if (lo_s[1])
					slave_addr <= ADDR_GND; // R12
				else
					slave_addr <= ADDR_FLOAT; // R12
			end
		end
	end

	// flags a clock high phase shorter than the variant allows
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			high_cnt      <= CNT_RST;
			bus_fast_seen <= 1'b0;
		end else if (scl_s[1]) begin
			if (high_cnt != 32'hffff_ffff)
				high_cnt <= high_cnt + 32'h0000_0001;
		end else begin
			high_cnt <= CNT_RST;
			if (high_cnt != CNT_RST && high_cnt < 32'(HALF_CYC))
				bus_fast_seen <= 1'b1; // R11
		end
	end

	// checks
	sequence seq_conv_done;
		conv_end && cfg.power_on;
	endsequence

	sequence seq_restart;
		state == ST_XFER ##1 state == ST_INTEG;
	endsequence

	a_result_capture: assert property (@(posedge mclk) disable iff (!rstn)
		seq_conv_done |=> shadow == $past(adc_res) && shadow_full) // R2
		else $error("shadow did not capture both channels");

	a_no_tear_read: assert property (@(posedge mclk) disable iff (!rstn)
		host_rd_busy |=> $stable(data) && !data_new) // R3
		else $error("data changed during a host read");

	a_auto_restart: assert property (@(posedge mclk) disable iff (!rstn)
		seq_conv_done ##1 cfg.power_on |-> seq_restart) // R4
		else $error("integration did not restart");

	a_window_shared: assert property (@(posedge mclk) disable iff (!rstn)
		integ_run |-> $past(state) == ST_INTEG) // R1
		else $error("integration window outside integrate state");

	a_int_level_hold: assert property (@(posedge mclk) disable iff (!rstn)
		int_oe && !clear_any |=> int_oe) // R8
		else $error("interrupt dropped without clear");

	a_int_set_wins: assert property (@(posedge mclk) disable iff (!rstn)
		fire && cfg.int_en |=> int_oe) // R6
		else $error("threshold event lost");

	a_persist_gate: assert property (@(posedge mclk) disable iff (!rstn)
		fire |-> outside && cfg.persist <= next_pcnt + 4'h0 ||
			cfg.persist == PCNT_RST) // R7
		else $error("interrupt before persistence met");

	a_open_drain: assert property (@(posedge mclk) disable iff (!rstn)
		int_o == 1'b0) // R10
		else $error("interrupt pin driven high");

	a_pdown_halt: assert property (@(posedge mclk) disable iff (!rstn)
		!cfg.power_on ##1 !cfg.power_on |-> !integ_run && !conv_end) // R15
		else $error("conversion ran in power down");

	a_strap_frozen: assert property (@(posedge mclk) disable iff (!rstn)
		strap_done |=> $stable(slave_addr)) // R12
		else $error("slave address changed after strap");

	a_alert_clear: assert property (@(posedge mclk) disable iff (!rstn)
		SMBUS_VARIANT && alert_resp && !(fire && cfg.int_en) |=> !int_oe) // R9
		else $error("alert response did not release interrupt");

endmodule : lcc_ctrl

// ===== dv/lcc_adc_model.sv
// Purpose: behavioural pair of integrating converters
// Assumes: result is taken while the integration window is open
// Notes:   outside the window the outputs invert, so late samples show
module lcc_adc_model
	import lcc_pkg::*;
(
	// window and light level
	input  wire logic      integ_run,
	input  wire lcc_pair_t level,
	// results
	output      lcc_pair_t adc_res
);
	timeunit 1ns;
	timeprecision 1ps;
	assign adc_res = integ_run ? level : ~level;
endmodule : lcc_adc_model

// ===== dv/lcc_ctrl_bench.sv
// Purpose: self-checking bench of the light conversion controller
// Assumes: short integration counts 20/30/40, level interrupt variant
// Notes:   inputs change 1 ns after the rising edge, checks at negedge
module lcc_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import lcc_pkg::*;
	// scl idles high as on a pulled-up bus
	logic       mclk = 0, rstn = 0, busy = 0, clr = 0, scl = 1;
	logic       alert = 0, strap_hi = 0, strap_lo = 0;
	lcc_cfg_t   cfg = '0;
	lcc_thr_t   thr = '0;
	lcc_pair_t  lvl = 32'h1234_fedc, adc, data;
	logic       run, gain, dnew, int_o, int_oe, fast;
	logic [6:0] addr;
	int         failures = 0, check_count = 0, cyc = 0, n;

	always #2.5 mclk = ~mclk;

	lcc_adc_model u_lcc_adc_model (.integ_run(run), .level(lvl),
		.adc_res(adc));
	lcc_ctrl #(.INTEG_CYC_S(20), .INTEG_CYC_M(30), .INTEG_CYC_L(40))
	u_lcc_ctrl (.mclk(mclk), .rstn(rstn), .cfg(cfg), .thr(thr),
		.host_rd_busy(busy), .int_clear(clr), .alert_resp(alert),
		.adc_res(adc), .integ_run(run), .adc_gain(gain), .data(data),
		.data_new(dnew), .scl_pin(scl), .strap_hi_pin(strap_hi),
		.strap_lo_pin(strap_lo), .int_o(int_o), .int_oe(int_oe),
		.slave_addr(addr), .bus_fast_seen(fast));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop

	// hang guard: the whole run needs well under 2000 cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 4000) begin
			failures++;
			report_and_stop();
		end
	end

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : chk

	// returns at the negedge where the one-cycle update pulse shows, or after 200 negedges without it
	task automatic wait_new(output int k);
		k = 0;
		do begin
			@(negedge mclk);
			k++;
		end while (dnew !== 1'b1 && k < 200);
	endtask : wait_new

	task automatic t_convert();
		@(posedge mclk) #1;
		cfg.power_on = 1;
		cfg.high_gain = 1;
		wait_new(n);
		chk("data", 32'h1234_fedc, data);
		chk("gain", 1, gain);
		chk("masked", 0, int_oe);
		for (int i = 0; i < 3; i++) begin
			@(posedge mclk) #1;
			cfg.integ = i[1:0];
			wait_new(n);
			wait_new(n);
			chk("period", 21 + 10 * i, n);
		end
		$display("convert done");
	endtask : t_convert

	task automatic t_freeze();
		@(posedge mclk) #1;
		busy = 1;
		lvl = 32'haaaa_5555;
		repeat (90) @(negedge mclk);
		chk("frozen", 32'h1234_fedc, data);
		@(posedge mclk) #1;
		busy = 0;
		wait_new(n);
		chk("released", 32'haaaa_5555, data);
		$display("freeze done");
	endtask : t_freeze

	task automatic t_irq();
		@(posedge mclk) #1;
		cfg.integ = 0;
		thr = {16'hffff, 16'h0000};
		cfg.persist = 4'h2;
		cfg.int_en = 1;
		wait_new(n);
		wait_new(n);
		@(posedge mclk) #1;
		thr.upper = 16'h1000;
		wait_new(n);
		chk("one over", 0, int_oe);
		wait_new(n);
		chk("two over", 1, int_oe);
		chk("pin low", 0, int_o);
		@(posedge mclk) #1;
		thr = {16'hffff, 16'h0000};
		wait_new(n);
		wait_new(n);
		chk("held", 1, int_oe);
		@(posedge mclk) #1;
		alert = 1;
		@(posedge mclk) #1;
		alert = 0;
		@(negedge mclk);
		chk("alert ignored", 1, int_oe);
		@(posedge mclk) #1;
		clr = 1;
		@(posedge mclk) #1;
		clr = 0;
		thr.lower = 16'hb000;
		@(negedge mclk);
		chk("cleared", 0, int_oe);
		wait_new(n);
		wait_new(n);
		wait_new(n);
		chk("under", 1, int_oe);
		$display("interrupt done");
	endtask : t_irq

	task automatic t_power();
		@(posedge mclk) #1;
		cfg.power_on = 0;
		repeat (3) @(negedge mclk);
		chk("halted", 0, run);
		wait_new(n);
		chk("no result", 200, n);
		chk("address", 7'h21, addr);
		@(posedge mclk) #1;
		scl = 0;
		repeat (6) @(negedge mclk);
		chk("slow bus", 0, fast);
		@(posedge mclk) #1;
		scl = 1;
		repeat (10) @(posedge mclk);
		#1 scl = 0;
		repeat (6) @(negedge mclk);
		chk("fast bus", 1, fast);
		@(posedge mclk) #1;
		scl = 1;
		$display("power done");
	endtask : t_power

	// mid-run resets: strap re-sampled, sticky bus flag cleared
	task automatic t_strap();
		for (int i = 0; i < 2; i++) begin
			@(posedge mclk) #1;
			strap_hi = (i == 0);
			strap_lo = 1;
			rstn = 0;
			repeat (3) @(posedge mclk);
			#1 rstn = 1;
			repeat (4) @(negedge mclk);
			chk("strap", (i == 0) ? 7'h22 : 7'h20, addr);
			chk("fast reset", 0, fast);
		end
		$display("strap done");
	endtask : t_strap

	initial begin
		repeat (3) @(posedge mclk);
		#1 rstn = 1;
		t_convert();
		t_freeze();
		t_irq();
		t_power();
		t_strap();
		report_and_stop();
	end
endmodule : lcc_ctrl_bench
